// ---- shared/sfm_pkg.sv ----
// package of the upset monitor suite: register map, field layout,
// reset values, checksum walk and the bundles that travel between modules.
// assumes a 16-bit management register space and a 16-bit config readout.
`default_nettype none

package sfm_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [15:0] ADDR_IRQ_MASK = 16'h01D7; // interrupt mask, pll status
	localparam logic [15:0] ADDR_FAULT_STAT = 16'h01D8; // fault status and state mask
	localparam logic [15:0] ADDR_PLL_CFG = 16'h01D9; // lock window, relock count, pin
	localparam logic [15:0] ADDR_TEMP_CTRL = 16'h01E8; // threshold, enable, status
	localparam logic [15:0] ADDR_TEMP_READ = 16'h01EA; // last sensor sample
	localparam logic [15:0] ADDR_PROT_EN = 16'h01EE; // config protection enables

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int STATE_STAT_LSB = 0; // state fault status 11:0
	localparam int STATE_STAT_W = 12;
	localparam int STATE_HALF_W = 6; // mask bit 0 covers 5:0, bit 1 covers 11:6
	localparam int CFG_STAT_LSB = 12; // config fault status 14:12
	localparam int CFG_STAT_W = 3;
	localparam int CFG_BIT_CORR = 0; // ecc corrected a bit
	localparam int CFG_BIT_DET = 1; // ecc detected an error
	localparam int CFG_BIT_SUM = 2; // running checksum differs
	localparam int PROT_LSB = 7; // protection enables 9:7
	localparam int PROT_W = 3;
	localparam int PLL_MASK_BIT = 11; // loss-of-lock mask
	localparam int PLL_STAT_BIT = 12; // loss-of-lock status, read only
	localparam int PLL_WIN_LSB = 0; // phase error window 7:0
	localparam int PLL_CNT_LSB = 8; // relock count 14:8
	localparam int PLL_PIN_BIT = 15; // upset pin function select
	localparam int TEMP_EN_BIT = 8; // temperature watch enable
	localparam int TEMP_STAT_BIT = 15; // temperature fault status
	localparam logic [6:0] TEMP_PERCENT = 7'h64; // one hundred percent

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [15:0] RST_IRQ_MASK = 16'hFFFF; // everything masked
	localparam logic [15:0] RST_PLL_CFG = 16'h2010; // window 16, relock 32, no pin
	localparam logic [7:0] RST_TEMP_THR = 8'h0A; // ten percent
	localparam logic [2:0] RST_PROT = 3'h0; // protection off
	localparam logic [1:0] RST_STATE_MASK = 2'h0; // state faults unmasked

	// ************************************************************
	// checksum walk
	// ************************************************************
	localparam int CFG_NUM = 32; // configuration registers covered
	localparam int CFG_AW = 5; // index width
	localparam logic [4:0] CFG_LAST = 5'h1F; // last index of the walk

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		CK_IDLE = 2'b00, // waiting for work
		CK_GOLD = 2'b01, // building the golden sum
		CK_RUN = 2'b10 // building a running sum
	} sfm_ck_mode_type;

	typedef struct packed {
		logic rd; // read strobe, one cycle
		logic wr; // write strobe, one cycle
		logic [15:0] addr; // register address
		logic [15:0] wdata; // write data
	} sfm_reg_req_type;

	typedef struct packed {
		logic valid; // read data valid, one cycle
		logic [15:0] data; // read data
	} sfm_reg_rsp_type;

	// rotate-left then xor: order sensitive, so a swapped pair shows
	function automatic logic [15:0] sfm_sum_step(input logic [15:0] acc, input logic [15:0] d);
		sfm_sum_step = {acc[14:0], acc[15]} ^ d;
	endfunction

endpackage : sfm_pkg

`default_nettype wire

// ---- hdl/sfm_checksum.sv ----
// checksum walker: reads every configuration register in address order.
// assumes cfg_data answers cfg_addr in the same cycle.
`default_nettype none

module sfm_checksum (
	input wire logic mclk, // core clock
	input wire logic sys_rst, // synchronous reset, high
	input wire logic start, // begin a walk, pulse
	input wire logic abort, // drop the walk, pulse
	input wire logic [15:0] cfg_data, // config word at cfg_addr
	output logic [sfm_pkg::CFG_AW-1:0] cfg_addr, // config index being read
	output logic done, // walk finished, pulse
	output logic [15:0] sum // finished checksum
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic busy; // walk in progress
		logic [sfm_pkg::CFG_AW-1:0] idx; // current index
		logic [15:0] acc; // partial sum
		logic done; // finish pulse
		logic [15:0] sum; // held result
	} sfm_walk_type;

	sfm_walk_type st_ff;
	sfm_walk_type nxt_st;

	// next state of the walk
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (abort) begin
			// abort wins so a stopped check never reports
			nxt_st.busy = 1'b0;
			nxt_st.idx = '0;
		end else if (st_ff.busy) begin
			// same step and order for golden and running sums
			nxt_st.acc = sfm_pkg::sfm_sum_step(st_ff.acc, cfg_data);
			if (st_ff.idx == sfm_pkg::CFG_LAST) begin
				nxt_st.busy = 1'b0;
				nxt_st.done = 1'b1;
				nxt_st.sum = sfm_pkg::sfm_sum_step(st_ff.acc, cfg_data);
				nxt_st.idx = '0;
			end else begin
				nxt_st.idx = st_ff.idx + 1'b1; // walk by address
			end
		end else if (start) begin
			nxt_st.busy = 1'b1;
			nxt_st.idx = '0;
			nxt_st.acc = '0;
		end
	end

	// register the walk
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cfg_addr = st_ff.idx;
	assign done = st_ff.done;
	assign sum = st_ff.sum;

endmodule // sfm_checksum

`default_nettype wire

// ---- hdl/sfm_monitor.sv ----
// upset monitor suite: pcs state faults, config checksum watch,
// temperature jump watch and pll lock watch, with management registers.
// assumes all inputs synchronous to mclk; ref_tick marks reference cycles.
`default_nettype none

module sfm_monitor (
	input wire logic mclk, // core clock
	input wire logic sys_rst, // synchronous reset, high
	input wire sfm_pkg::sfm_reg_req_type reg_req, // management access
	output sfm_pkg::sfm_reg_rsp_type reg_rsp, // management read answer
	input wire logic [11:0] pcs_bad_trans, // illegal pcs transition seen, pulses
	input wire logic auto_recover, // recovery strap level
	input wire logic ecc_corrected, // ecc corrected a config bit, pulse
	input wire logic ecc_detected, // ecc found an error, pulse
	input wire logic management_lockout_input, // lockout level
	input wire logic [15:0] cfg_data, // config word at cfg_addr
	output logic [sfm_pkg::CFG_AW-1:0] cfg_addr, // config index being read
	input wire logic temp_valid, // new sensor sample, pulse
	input wire logic [15:0] temp_sample, // sensor sample
	input wire logic [7:0] pll_phase_err, // phase error magnitude
	input wire logic ref_tick, // one reference clock cycle, pulse
	output logic state_fault_irq_n, // state fault interrupt, low
	output logic cfg_fault_irq_n, // config fault interrupt, low
	output logic temperature_fault_irq_n, // temperature interrupt, low
	output logic upset_irq_n, // loss-of-lock on the upset pin, low
	output logic pll_locked, // lock indication
	output logic pcs_reset_req, // internal logic reset, pulse
	output logic cfg_restore_req // restore config defaults, pulse
);

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		sfm_pkg::sfm_reg_rsp_type rsp; // read answer
		logic [11:0] state_stat; // sticky state faults
		logic [1:0] state_mask; // state fault masks
		logic [2:0] cfg_stat; // sticky config faults
		logic [2:0] prot_en; // protection enables
		logic [15:0] irq_mask; // interrupt mask register
		logic [15:0] pll_cfg; // window, relock count, pin select
		logic pll_lost; // sticky loss of lock
		logic pll_lock; // lock indication
		logic [6:0] pll_cnt; // aligned reference cycles
		logic [7:0] temp_thr; // jump threshold in percent
		logic temp_en; // temperature watch on
		logic temp_stat; // sticky temperature fault
		logic temp_have; // a reference sample exists
		logic [15:0] temp_last; // last sample
		logic [15:0] golden; // golden checksum
		logic golden_ok; // golden valid
		logic gold_pend; // golden build wanted
		sfm_pkg::sfm_ck_mode_type mode; // checksum controller
		logic lock_q; // lockout, last cycle
		logic chk_start; // walker start
		logic chk_abort; // walker abort
		logic state_irq_n; // state interrupt pin
		logic cfg_irq_n; // config interrupt pin
		logic temp_irq_n; // temperature interrupt pin
		logic upset_irq_n; // upset interrupt pin
		logic pcs_rst; // reset pulse
		logic cfg_rst; // restore pulse
	} sfm_mon_type;

	sfm_mon_type st_ff;
	sfm_mon_type nxt_st;

	logic chk_done; // walker finished
	logic [15:0] chk_sum; // walker result, the golden or the running checksum

	// ************************************************************
	// checksum walker
	// ************************************************************
	sfm_checksum u_checksum (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.start(st_ff.chk_start),
		.abort(st_ff.chk_abort),
		.cfg_data(cfg_data),
		.cfg_addr(cfg_addr),
		.done(chk_done),
		.sum(chk_sum)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	// true when a sample moved further than thr percent of the last one
	function automatic logic temp_jump(input logic [15:0] cur, input logic [15:0] last,
		input logic [7:0] thr);
		logic [15:0] diff;
		logic [23:0] lhs;
		logic [23:0] rhs;
		diff = (cur > last) ? (cur - last) : (last - cur);
		lhs = 24'(diff) * 24'(sfm_pkg::TEMP_PERCENT);
		rhs = 24'(last) * 24'(thr);
		temp_jump = lhs > rhs;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic rd_fault;
		logic rd_mask;
		logic rd_temp;
		logic lock_rise;
		logic lock_fall;
		logic [2:0] cfg_evt;
		logic [11:0] state_unmask;
		logic [15:0] rdata;
		rd_fault = 1'b0;
		rd_mask = 1'b0;
		rd_temp = 1'b0;
		lock_rise = 1'b0;
		lock_fall = 1'b0;
		cfg_evt = '0;
		state_unmask = '0;
		rdata = '0;
		nxt_st = st_ff;
		nxt_st.rsp.valid = 1'b0;
		nxt_st.chk_start = 1'b0;
		nxt_st.chk_abort = 1'b0;
		nxt_st.pcs_rst = 1'b0;
		nxt_st.cfg_rst = 1'b0;

		// register reads: answer next cycle, some clear status
		if (reg_req.rd) begin
			case (reg_req.addr)
				sfm_pkg::ADDR_IRQ_MASK: begin
					rdata = st_ff.irq_mask;
					rdata[sfm_pkg::PLL_STAT_BIT] = st_ff.pll_lost;
					rd_mask = 1'b1;
				end
				sfm_pkg::ADDR_FAULT_STAT: begin
					rdata = {1'b0, st_ff.cfg_stat, st_ff.state_stat};
					rd_fault = 1'b1;
				end
				sfm_pkg::ADDR_PLL_CFG: begin
					rdata = st_ff.pll_cfg;
				end
				sfm_pkg::ADDR_TEMP_CTRL: begin
					rdata = {st_ff.temp_stat, 6'h00, st_ff.temp_en, st_ff.temp_thr};
					rd_temp = 1'b1;
				end
				sfm_pkg::ADDR_TEMP_READ: begin
					rdata = st_ff.temp_last;
				end
				sfm_pkg::ADDR_PROT_EN: begin
					rdata = {6'h00, st_ff.prot_en, 7'h00};
				end
				default: begin
					rdata = '0; // unmapped reads as zero
				end
			endcase
			nxt_st.rsp.valid = 1'b1;
			nxt_st.rsp.data = rdata;
		end

		// register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				sfm_pkg::ADDR_IRQ_MASK: begin
					nxt_st.irq_mask = reg_req.wdata;
				end
				sfm_pkg::ADDR_FAULT_STAT: begin
					nxt_st.state_mask = reg_req.wdata[1:0];
				end
				sfm_pkg::ADDR_PLL_CFG: begin
					nxt_st.pll_cfg = reg_req.wdata;
				end
				sfm_pkg::ADDR_TEMP_CTRL: begin
					nxt_st.temp_thr = reg_req.wdata[7:0];
					nxt_st.temp_en = reg_req.wdata[sfm_pkg::TEMP_EN_BIT];
				end
				sfm_pkg::ADDR_PROT_EN: begin
					nxt_st.prot_en = reg_req.wdata[sfm_pkg::PROT_LSB +: sfm_pkg::PROT_W];
				end
				default: begin
					nxt_st.prot_en = nxt_st.prot_en; // other addresses ignored
				end
			endcase
		end

		// pcs state faults: read clears, a new event wins
		nxt_st.state_stat = (rd_fault ? 12'h000 : st_ff.state_stat) | pcs_bad_trans;
		if (|pcs_bad_trans && auto_recover) begin
			nxt_st.pcs_rst = 1'b1;
		end
		state_unmask = {{sfm_pkg::STATE_HALF_W{~nxt_st.state_mask[1]}},
			{sfm_pkg::STATE_HALF_W{~nxt_st.state_mask[0]}}};
		// raised with or without recovery, held until the read or a write that masks it
		nxt_st.state_irq_n = ~|(nxt_st.state_stat & state_unmask);

		// lockout edges
		lock_rise = management_lockout_input && !st_ff.lock_q;
		lock_fall = !management_lockout_input && st_ff.lock_q;
		nxt_st.lock_q = management_lockout_input;

		// checksum controller
		case (st_ff.mode)
			sfm_pkg::CK_IDLE: begin
				if (st_ff.gold_pend || lock_rise) begin
					nxt_st.chk_start = 1'b1;
					nxt_st.gold_pend = 1'b0;
					nxt_st.mode = sfm_pkg::CK_GOLD;
				end else if (management_lockout_input && st_ff.golden_ok && st_ff.prot_en[2]) begin
					nxt_st.chk_start = 1'b1;
					nxt_st.mode = sfm_pkg::CK_RUN;
				end
			end
			sfm_pkg::CK_GOLD: begin
				if (chk_done) begin
					nxt_st.golden = chk_sum;
					nxt_st.golden_ok = 1'b1;
					nxt_st.mode = sfm_pkg::CK_IDLE;
				end
			end
			sfm_pkg::CK_RUN: begin
				if (chk_done) begin
					cfg_evt[sfm_pkg::CFG_BIT_SUM] = chk_sum != st_ff.golden;
					nxt_st.mode = sfm_pkg::CK_IDLE;
				end
			end
			default: begin
				nxt_st.mode = sfm_pkg::CK_IDLE;
			end
		endcase
		// a rise mid-walk restarts the golden build
		if (lock_rise && st_ff.mode != sfm_pkg::CK_IDLE) begin
			nxt_st.chk_abort = 1'b1;
			nxt_st.chk_start = 1'b0;
			nxt_st.gold_pend = 1'b1;
			nxt_st.mode = sfm_pkg::CK_IDLE;
		end
		// a fall drops the golden value and any walk
		if (lock_fall) begin
			nxt_st.golden = '0;
			nxt_st.golden_ok = 1'b0;
			nxt_st.chk_abort = 1'b1;
			nxt_st.chk_start = 1'b0;
			nxt_st.mode = sfm_pkg::CK_IDLE;
			cfg_evt[sfm_pkg::CFG_BIT_SUM] = 1'b0;
		end

		// config faults: ecc events gated by their enables
		cfg_evt[sfm_pkg::CFG_BIT_CORR] = ecc_corrected && st_ff.prot_en[0];
		cfg_evt[sfm_pkg::CFG_BIT_DET] = ecc_detected && st_ff.prot_en[1];
		nxt_st.cfg_stat = (rd_fault ? 3'h0 : st_ff.cfg_stat) | cfg_evt;
		if ((cfg_evt[sfm_pkg::CFG_BIT_SUM] || cfg_evt[sfm_pkg::CFG_BIT_DET]) && auto_recover) begin
			nxt_st.cfg_rst = 1'b1;
		end
		nxt_st.cfg_irq_n = ~|nxt_st.cfg_stat;

		// temperature: compare each sample with the one before
		if (temp_valid) begin
			if (st_ff.temp_en && st_ff.temp_have &&
				temp_jump(temp_sample, st_ff.temp_last, st_ff.temp_thr)) begin
				nxt_st.temp_stat = 1'b1;
			end else if (rd_temp) begin
				nxt_st.temp_stat = 1'b0;
			end
			nxt_st.temp_last = temp_sample;
			nxt_st.temp_have = 1'b1;
		end else if (rd_temp) begin
			nxt_st.temp_stat = 1'b0;
		end
		nxt_st.temp_irq_n = ~nxt_st.temp_stat;

		// pll lock detector
		if (pll_phase_err > st_ff.pll_cfg[sfm_pkg::PLL_WIN_LSB +: 8]) begin
			nxt_st.pll_lock = 1'b0;
			nxt_st.pll_cnt = '0;
			nxt_st.pll_lost = st_ff.pll_lock || (st_ff.pll_lost && !rd_mask);
		end else begin
			if (rd_mask) begin
				nxt_st.pll_lost = 1'b0;
			end
			if (!st_ff.pll_lock && ref_tick) begin
				if (st_ff.pll_cnt == st_ff.pll_cfg[sfm_pkg::PLL_CNT_LSB +: 7]) begin
					nxt_st.pll_lock = 1'b1;
				end else begin
					nxt_st.pll_cnt = st_ff.pll_cnt + 1'b1;
				end
			end
		end
		// only out when unmasked and the pin function is selected
		nxt_st.upset_irq_n = ~(nxt_st.pll_lost && !nxt_st.irq_mask[sfm_pkg::PLL_MASK_BIT] &&
			nxt_st.pll_cfg[sfm_pkg::PLL_PIN_BIT]);
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.state_mask <= sfm_pkg::RST_STATE_MASK;
			st_ff.prot_en <= sfm_pkg::RST_PROT;
			st_ff.irq_mask <= sfm_pkg::RST_IRQ_MASK;
			st_ff.pll_cfg <= sfm_pkg::RST_PLL_CFG;
			st_ff.temp_thr <= sfm_pkg::RST_TEMP_THR;
			st_ff.gold_pend <= 1'b1; // golden build after power-on
			st_ff.mode <= sfm_pkg::CK_IDLE;
			st_ff.state_irq_n <= 1'b1;
			st_ff.cfg_irq_n <= 1'b1;
			st_ff.temp_irq_n <= 1'b1;
			st_ff.upset_irq_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************************************************
	// outputs, all from flip-flops
	// ************************************************************
	assign reg_rsp = st_ff.rsp;
	assign state_fault_irq_n = st_ff.state_irq_n;
	assign cfg_fault_irq_n = st_ff.cfg_irq_n;
	assign temperature_fault_irq_n = st_ff.temp_irq_n;
	assign upset_irq_n = st_ff.upset_irq_n;
	assign pll_locked = st_ff.pll_lock;
	assign pcs_reset_req = st_ff.pcs_rst;
	assign cfg_restore_req = st_ff.cfg_rst;

endmodule // sfm_monitor

`default_nettype wire

// ---- testbench/sfm_monitor_asserts.sv ----
// checker: timing relations at the ports of the upset monitor
// assumes it is bound to sfm_monitor, one clock, sync reset high
`default_nettype none
module sfm_monitor_asserts (
	input wire logic mclk, // core clock
	input wire logic sys_rst, // sync reset
	input wire sfm_pkg::sfm_reg_req_type reg_req, // access
	input wire sfm_pkg::sfm_reg_rsp_type reg_rsp, // answer
	input wire logic [11:0] pcs_bad_trans, // pcs events
	input wire logic auto_recover, // recovery strap
	input wire logic temp_valid, // sample strobe
	input wire logic [7:0] pll_phase_err, // phase error
	input wire logic ref_tick, // reference cycle
	input wire logic state_fault_irq_n, // state irq
	input wire logic cfg_fault_irq_n, // config irq
	input wire logic temperature_fault_irq_n, // temp irq
	input wire logic upset_irq_n, // lock irq
	input wire logic pll_locked, // lock flag
	input wire logic pcs_reset_req, // logic reset
	input wire logic cfg_restore_req // config restore
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// sequences and assertions
	// ****
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// status read with no new pcs event
	sequence s_stat_read;
		reg_req.rd && reg_req.addr == sfm_pkg::ADDR_FAULT_STAT && pcs_bad_trans == 12'h000;
	endsequence
	// no pcs event in the cycle after
	sequence s_quiet;
		pcs_bad_trans == 12'h000;
	endsequence
	chk_reset_idle: assert property (disable iff (1'b0) sys_rst |=> state_fault_irq_n &&
		cfg_fault_irq_n && temperature_fault_irq_n && upset_irq_n && !pll_locked)
		else $error("outputs not idle after reset");
	chk_read_clears: assert property (s_stat_read ##1 s_quiet |=> state_fault_irq_n)
		else $error("state irq not cleared by read");
	chk_irq_sticky: assert property (!state_fault_irq_n && !(reg_req.rd || reg_req.wr) &&
		!$past(reg_req.rd) |=> !state_fault_irq_n)
		else $error("state irq released without read");
	chk_irq_cause: assert property ($fell(state_fault_irq_n) |->
		$past(pcs_bad_trans) != 12'h000 || $past(reg_req.wr))
		else $error("state irq without event");
	chk_recover_req: assert property (pcs_bad_trans != 12'h000 && auto_recover |=> pcs_reset_req)
		else $error("no internal reset on pcs fault");
	chk_restore_cause: assert property (cfg_restore_req |-> $past(auto_recover))
		else $error("restore without recovery");
	chk_rsp_timing: assert property (reg_req.rd |=> reg_rsp.valid)
		else $error("read answer missing");
	chk_temp_cause: assert property ($fell(temperature_fault_irq_n) |-> $past(temp_valid))
		else $error("temp irq without sample");
	chk_lock_drop: assert property ($fell(pll_locked) |-> $past(pll_phase_err) != 8'h00)
		else $error("lock dropped without error");
	chk_relock_tick: assert property ($rose(pll_locked) |-> $past(ref_tick))
		else $error("lock rose without tick");
endmodule // sfm_monitor_asserts
`default_nettype wire

// ---- testbench/sfm_host_model.sv ----
// far side model: configuration words read by the checksum walker
// assumes cfg_data is answered combinationally from cfg_addr
`default_nettype none
module sfm_host_model (
	input wire logic [sfm_pkg::CFG_AW-1:0] cfg_addr, // index asked
	input wire logic corrupt, // upset one stored word
	output logic [15:0] cfg_data // word answered
);
	timeunit 1ns;
	timeprecision 100ps;
	// fixed pattern per index, word five hit on demand
	always_comb begin
		cfg_data = {3'h5, cfg_addr, 3'h2, cfg_addr};
		if (corrupt && cfg_addr == 5'h05) begin
			cfg_data = cfg_data ^ 16'h0100; // one flipped bit
		end
	end
endmodule // sfm_host_model
`default_nettype wire

// ---- testbench/tb_sfm_monitor.sv ----
// testbench: register reach, the four monitors and recovery requests
// assumes sfm_monitor, sfm_host_model and the checker are compiled before
`default_nettype none
module tb_sfm_monitor;
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// signals
	// ****
	logic mclk, sys_rst, auto_recover, ecc_corrected, ecc_detected, corrupt;
	logic management_lockout_input, temp_valid, ref_tick;
	logic state_fault_irq_n, cfg_fault_irq_n, temperature_fault_irq_n, upset_irq_n;
	logic pll_locked, pcs_reset_req, cfg_restore_req;
	logic [11:0] pcs_bad_trans; // pcs events
	logic [15:0] cfg_data, temp_sample; // config word, sample
	logic [7:0] pll_phase_err; // phase error
	logic [sfm_pkg::CFG_AW-1:0] cfg_addr; // walker index
	sfm_pkg::sfm_reg_req_type reg_req; // access
	sfm_pkg::sfm_reg_rsp_type reg_rsp; // answer
	int num_errors, comparisons;
	sfm_monitor sfm_monitor_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req),
		.reg_rsp(reg_rsp), .pcs_bad_trans(pcs_bad_trans), .auto_recover(auto_recover),
		.ecc_corrected(ecc_corrected), .ecc_detected(ecc_detected),
		.management_lockout_input(management_lockout_input), .cfg_data(cfg_data),
		.cfg_addr(cfg_addr), .temp_valid(temp_valid), .temp_sample(temp_sample),
		.pll_phase_err(pll_phase_err), .ref_tick(ref_tick),
		.state_fault_irq_n(state_fault_irq_n), .cfg_fault_irq_n(cfg_fault_irq_n),
		.temperature_fault_irq_n(temperature_fault_irq_n), .upset_irq_n(upset_irq_n),
		.pll_locked(pll_locked), .pcs_reset_req(pcs_reset_req),
		.cfg_restore_req(cfg_restore_req));
	sfm_host_model sfm_host_model_inst (.cfg_addr(cfg_addr), .corrupt(corrupt),
		.cfg_data(cfg_data));
	// ****
	// shared tasks
	// ****
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge mclk);
		reg_req.wr <= 1'b0;
	endtask
	// read, answer looked at in its one valid cycle
	task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
		@(posedge mclk);
		reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
		@(posedge mclk);
		reg_req.rd <= 1'b0;
		#1;
		check("read valid", 16'h0001, {15'h0000, reg_rsp.valid});
		check("read data", exp, reg_rsp.data);
	endtask
	task automatic pcs_evt(input logic [11:0] bits, input logic ar);
		@(posedge mclk);
		pcs_bad_trans <= bits;
		auto_recover <= ar;
		@(posedge mclk);
		pcs_bad_trans <= 12'h000;
		#1;
	endtask
	task automatic temp_in(input logic [15:0] v);
		@(posedge mclk);
		temp_valid <= 1'b1;
		temp_sample <= v;
		@(posedge mclk);
		temp_valid <= 1'b0;
		#1;
	endtask
	task automatic lock_ticks;
		for (int i = 1; i <= 4; i++) begin
			@(posedge mclk);
			ref_tick <= 1'b1;
			@(posedge mclk);
			ref_tick <= 1'b0;
			#1;
			check("lock", (i == 4) ? 16'h0001 : 16'h0000, {15'h0000, pll_locked});
		end
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_reset_vals;
		check("irq idle", 16'h000F, {12'h000, state_fault_irq_n, cfg_fault_irq_n,
			temperature_fault_irq_n, upset_irq_n});
		reg_rd(sfm_pkg::ADDR_IRQ_MASK, sfm_pkg::RST_IRQ_MASK & 16'hEFFF);
		reg_rd(sfm_pkg::ADDR_PLL_CFG, sfm_pkg::RST_PLL_CFG);
		reg_rd(sfm_pkg::ADDR_TEMP_CTRL, {8'h00, sfm_pkg::RST_TEMP_THR});
		reg_rd(sfm_pkg::ADDR_PROT_EN, 16'h0000);
		reg_rd(16'h0100, 16'h0000);
	endtask
	task automatic t_state;
		pcs_evt(12'h008, 1'b1);
		check("state irq", 16'h0000, {15'h0000, state_fault_irq_n});
		check("reset req", 16'h0001, {15'h0000, pcs_reset_req});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h0008);
		@(posedge mclk);
		#1;
		check("state irq", 16'h0001, {15'h0000, state_fault_irq_n});
		reg_wr(sfm_pkg::ADDR_FAULT_STAT, 16'h0001);
		pcs_evt(12'h004, 1'b0);
		check("masked irq", 16'h0001, {15'h0000, state_fault_irq_n});
		check("reset req", 16'h0000, {15'h0000, pcs_reset_req});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h0004);
		pcs_evt(12'h800, 1'b0);
		check("state irq", 16'h0000, {15'h0000, state_fault_irq_n});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h0800);
		reg_wr(sfm_pkg::ADDR_FAULT_STAT, 16'h0003);
		pcs_evt(12'h041, 1'b0);
		check("masked irq", 16'h0001, {15'h0000, state_fault_irq_n});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h0041);
	endtask
	task automatic t_ecc;
		reg_wr(sfm_pkg::ADDR_PROT_EN, 16'h0380);
		reg_rd(sfm_pkg::ADDR_PROT_EN, 16'h0380);
		@(posedge mclk);
		ecc_corrected <= 1'b1;
		@(posedge mclk);
		ecc_corrected <= 1'b0;
		#1;
		check("cfg irq", 16'h0000, {15'h0000, cfg_fault_irq_n});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h1000);
		@(posedge mclk);
		ecc_detected <= 1'b1;
		auto_recover <= 1'b1;
		@(posedge mclk);
		ecc_detected <= 1'b0;
		auto_recover <= 1'b0;
		#1;
		check("restore req", 16'h0001, {15'h0000, cfg_restore_req});
		check("cfg irq", 16'h0000, {15'h0000, cfg_fault_irq_n});
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h2000);
	endtask
	task automatic t_checksum;
		@(posedge mclk);
		management_lockout_input <= 1'b1;
		repeat (100) @(posedge mclk);
		check("cfg irq", 16'h0001, {15'h0000, cfg_fault_irq_n});
		corrupt <= 1'b1;
		for (int i = 0; i < 200 && cfg_fault_irq_n; i++) @(posedge mclk);
		if (cfg_fault_irq_n !== 1'b0) begin
			check("cfg irq", 16'h0000, {15'h0000, cfg_fault_irq_n});
			finish_test();
		end
		management_lockout_input <= 1'b0;
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h4000);
		repeat (100) @(posedge mclk);
		management_lockout_input <= 1'b1;
		reg_rd(sfm_pkg::ADDR_FAULT_STAT, 16'h0000);
		repeat (100) @(posedge mclk);
		check("cfg irq", 16'h0001, {15'h0000, cfg_fault_irq_n});
		management_lockout_input <= 1'b0;
		corrupt <= 1'b0;
	endtask
	task automatic t_temp;
		reg_wr(sfm_pkg::ADDR_TEMP_CTRL, 16'h010A);
		temp_in(16'h03E8);
		temp_in(16'h041A);
		temp_in(16'h0483);
		check("temp irq", 16'h0001, {15'h0000, temperature_fault_irq_n});
		temp_in(16'h0514);
		check("temp irq", 16'h0000, {15'h0000, temperature_fault_irq_n});
		reg_rd(sfm_pkg::ADDR_TEMP_READ, 16'h0514);
		reg_rd(sfm_pkg::ADDR_TEMP_CTRL, 16'h810A);
		@(posedge mclk);
		#1;
		check("temp irq", 16'h0001, {15'h0000, temperature_fault_irq_n});
	endtask
	task automatic t_pll;
		reg_wr(sfm_pkg::ADDR_IRQ_MASK, 16'hF7FF);
		reg_wr(sfm_pkg::ADDR_PLL_CFG, 16'h8310);
		lock_ticks();
		@(posedge mclk);
		pll_phase_err <= 8'h10;
		@(posedge mclk);
		pll_phase_err <= 8'h11;
		@(posedge mclk);
		pll_phase_err <= 8'h00;
		#1;
		check("lock drop", 16'h0000, {15'h0000, pll_locked});
		@(posedge mclk);
		#1;
		check("upset irq", 16'h0000, {15'h0000, upset_irq_n});
		reg_rd(sfm_pkg::ADDR_IRQ_MASK, 16'hF7FF);
		reg_rd(sfm_pkg::ADDR_IRQ_MASK, 16'hE7FF);
		lock_ticks();
		check("upset irq", 16'h0001, {15'h0000, upset_irq_n});
	endtask
	// ****
	// clock and main sequence
	// ****
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		num_errors = 0;
		comparisons = 0;
		sys_rst = 1'b1;
		reg_req = '0;
		{auto_recover, ecc_corrected, ecc_detected, corrupt} = 4'h0;
		{management_lockout_input, temp_valid, ref_tick} = 3'h0;
		pcs_bad_trans = 12'h000;
		temp_sample = 16'h0000;
		pll_phase_err = 8'h00;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (40) @(posedge mclk);
		t_reset_vals();
		t_state();
		t_ecc();
		t_checksum();
		t_temp();
		t_pll();
		finish_test();
	end
endmodule // tb_sfm_monitor
bind sfm_monitor sfm_monitor_asserts sfm_monitor_asserts_inst (.mclk(mclk), .sys_rst(sys_rst),
	.reg_req(reg_req), .reg_rsp(reg_rsp), .pcs_bad_trans(pcs_bad_trans),
	.auto_recover(auto_recover), .temp_valid(temp_valid), .pll_phase_err(pll_phase_err),
	.ref_tick(ref_tick), .state_fault_irq_n(state_fault_irq_n),
	.cfg_fault_irq_n(cfg_fault_irq_n), .temperature_fault_irq_n(temperature_fault_irq_n),
	.upset_irq_n(upset_irq_n), .pll_locked(pll_locked), .pcs_reset_req(pcs_reset_req),
	.cfg_restore_req(cfg_restore_req));
`default_nettype wire
